/* File: src/see_defs.vh */
`ifndef SEE_DEFS_VH
`define SEE_DEFS_VH
// Op-codes
`define SEE_OP_STAT_WRITE 8'h01
`define SEE_OP_WRITE      8'h02
`define SEE_OP_READ       8'h03
`define SEE_OP_CLR_LATCH  8'h04
`define SEE_OP_RDSTAT     8'h05
`define SEE_OP_SET_LATCH  8'h06
// Status field positions
`define SEE_ST_BUSY       0
`define SEE_ST_LATCH      1
`define SEE_ST_GUARD_LO   2
`define SEE_ST_GUARD_HI   3
`define SEE_ST_PIN_EN     7
// Writable status bits mask
`define SEE_ST_WR_MASK    8'h8C
// Reset values
`define SEE_ST_RESET      8'h00
// Array geometry
`define SEE_ADDR_BITS     13
`define SEE_PAGE_BITS     6
// Protected region bases
`define SEE_BASE_QUARTER  13'h1800
`define SEE_BASE_HALF     13'h1000
// Self-timed write time in us and cycles at 125 MHz
`define SEE_TWC_US        5000
`define SEE_CLK_MHZ       125
`define SEE_TWC_CYCLES    (`SEE_TWC_US * `SEE_CLK_MHZ)
`endif

/* File: src/see_fifo.v */
`timescale 1ns/1ps
// Small flip-flop FIFO between the serial engine and the array
module see_fifo #(
  parameter WIDTH = 14,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             rst,
  // Fill side
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  // Drain side
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage
  reg [AW:0]      wrPtr_q;         // Write pointer with wrap bit
  reg [AW:0]      rdPtr_q;         // Read pointer with wrap bit
  wire            empty = (wrPtr_q == rdPtr_q);
  wire            full  = (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]) && (wrPtr_q[AW] != rdPtr_q[AW]);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr_q[AW-1:0]];
  // Pointer update
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPtr_q <= {(AW+1){1'b0}};
      rdPtr_q <= {(AW+1){1'b0}};
    end else begin
      if (inValid && !full) wrPtr_q <= wrPtr_q + 1'b1;
      if (outReady && !empty) rdPtr_q <= rdPtr_q + 1'b1;
    end
  end
  // Storage write, no reset needed
  always @(posedge clk_sys) begin
    if (inValid && !full) mem[wrPtr_q[AW-1:0]] <= inData;
  end
endmodule // see_fifo

/* File: src/see_spi_eeprom.v */
// Functional notes
// - Only SPI modes 0,0 and 1,1 supported
// - First eight bits form op-code; others ignored
// - Array read op-code is 03
// - Array write op-code is 02
// - Set latch 06, clear latch 04
// - Status read 05, status write 01
// - Status byte layout: guard-enable, guards, latch, busy
// - Busy reads 1 during self-timed write
// - Latch set and cleared by commands
// - Latch clear at reset; writes need latch
// - Guard bits block writes, allow reads
// - Guard pair selects quarter, half, all
// - Pin low plus enable blocks status writes
// - Sixteen address bits, low thirteen used
// - Programming starts at select rise; busy ignores
// - Up to 32 bytes kept (FIFO depth), wrap inside 64-byte page
// - Latch clears when write cycle completes
// - Status write changes bits 2,3,7 only
// - Pin fall during status write aborts it if enable set
// - Read streams data after address, incrementing
// - Read wraps at top, runs until deselect
// - Status read allowed any time
// - Sample on rising, drive on falling edge
// - Output floats while deselected
// - Unknown op-code leaves output floating
`timescale 1ns/1ps
`include "see_defs.vh"
module see_spi_eeprom #(
  parameter TWC_CYCLES = `SEE_TWC_CYCLES, // Self-timed write length
  parameter PAGE_BYTES = 64,
  parameter FIFO_DEPTH = 32
) (
  // System
  input  wire clk_sys,
  input  wire rst,
  // Serial pins
  input  wire selN,        // Chip select, active low
  input  wire sclk,        // Serial clock from host
  input  wire sdIn,        // Serial data in
  input  wire guardPinN,   // Write guard pin, active low
  output reg  sdOut,       // Serial data out
  output reg  sdOutEnN,    // Output enable, low drives
  // Status view
  output reg  busy         // Self-timed write running
);
  localparam AB = `SEE_ADDR_BITS;
  localparam PB = `SEE_PAGE_BITS;
  // Sized copies so loads and compares keep their widths
  localparam [31:0] TWC32 = TWC_CYCLES;
  localparam [6:0]  PAGE7 = PAGE_BYTES;
  // One-hot phase states
  localparam ST_OP   = 6'h01;
  localparam ST_ADDR = 6'h02;
  localparam ST_WDAT = 6'h04;
  localparam ST_RDAT = 6'h08;
  localparam ST_SDAT = 6'h10;
  localparam ST_IGN  = 6'h20;
  // Two-flop synchronisers, then edge detect on third stage
  reg [2:0] selS_q, clkS_q, dinS_q, wpS_q;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      selS_q <= 3'h7;
      clkS_q <= 3'h0;
      dinS_q <= 3'h0;
      wpS_q  <= 3'h7;
    end else begin
      selS_q <= {selS_q[1:0], selN};
      clkS_q <= {clkS_q[1:0], sclk};
      dinS_q <= {dinS_q[1:0], sdIn};
      wpS_q  <= {wpS_q[1:0], guardPinN};
    end
  end
  wire selLow  = !selS_q[1];
  wire selFall = selS_q[2] && !selS_q[1];
  wire selRise = !selS_q[2] && selS_q[1];
  // Both modes sample on rise and shift on fall
  wire clkRise = selLow && !clkS_q[2] && clkS_q[1];
  wire clkFall = selLow && clkS_q[2] && !clkS_q[1];
  wire din     = dinS_q[1];
  wire pinLow  = !wpS_q[1];
  // Array storage and registers
  reg [7:0]    mem [0:(1<<AB)-1];   // Array cells
  reg [5:0]    state_q;             // Transaction phase
  reg [7:0]    shift_q;             // Input shift register
  reg [2:0]    bitCnt_q;            // Bit position in byte
  reg [15:0]   addr_q;              // Received address
  reg [AB-1:0] ptr_q;               // Read or write pointer
  reg          addrHi_q;            // Second address byte
  reg [7:0]    op_q;                // Latched op-code
  reg [7:0]    outByte_q;           // Output shift register
  reg          latch_q;             // Write-enable latch
  reg          gLo_q, gHi_q, pEn_q; // Nonvolatile status bits
  reg [7:0]    newStat_q;           // Pending status value
  reg          statPend_q;          // Status write armed
  reg          statAbort_q;         // Pin fell during it
  reg [6:0]    wrCnt_q;             // Bytes loaded this page
  reg          arrayPend_q;         // Array write armed
  reg          arrayBad_q;          // Page hits a guarded block
  reg [31:0]   twc_q;               // Write cycle timer
  reg          progArray_q;         // Running cycle is array
  // Status byte assembly
  wire [7:0] statByte = {pEn_q, 3'h0, gHi_q, gLo_q, latch_q, busy};
  // Guarded block
  function guarded;
    input [AB-1:0] a;
    input          hi, lo;
    begin
      case ({hi, lo})
        2'b01:   guarded = (a >= `SEE_BASE_QUARTER);
        2'b10:   guarded = (a >= `SEE_BASE_HALF);
        2'b11:   guarded = 1'b1;
        default: guarded = 1'b0;
      endcase
    end
  endfunction
  wire [7:0] nextIn = {shift_q[6:0], din}; // MSB first
  // Page data goes through the FIFO, address in upper bits
  // Only armed array writes load the FIFO; status bytes or refused
  // writes left in it would be programmed by a later page write
  wire          fInValid = clkRise && state_q == ST_WDAT && bitCnt_q == 3'h7
                           && op_q == `SEE_OP_WRITE && arrayPend_q;
  wire          fInReady;
  wire [PB+7:0] fInData  = {ptr_q[PB-1:0], nextIn};
  wire          fOutValid;
  wire [PB+7:0] fOutData;
  wire          commit   = busy && progArray_q && fOutValid;
  see_fifo #(.WIDTH(PB+8), .DEPTH(FIFO_DEPTH), .AW(5)) uFifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .inValid  (fInValid),
    .inReady  (fInReady),
    .inData   (fInData),
    .outValid (fOutValid),
    .outReady (commit),
    .outData  (fOutData)
  );
  // Bytes beyond the FIFO depth are dropped as overruns; the page base
  // is kept in pageBase_q so the commit knows which page to program.
  reg [AB-1:0] pageBase_q; // Page base for commit
  always @(posedge clk_sys) begin
    if (commit && !arrayBad_q)
      mem[{pageBase_q[AB-1:PB], fOutData[PB+7:8]}] <= fOutData[7:0];
  end
  // Main serial state machine
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q     <= ST_OP;
      shift_q     <= 8'h00;
      bitCnt_q    <= 3'h0;
      addr_q      <= 16'h0000;
      ptr_q       <= {AB{1'b0}};
      addrHi_q    <= 1'b0;
      op_q        <= 8'h00;
      outByte_q   <= 8'h00;
      latch_q     <= 1'b0; // Powers up write-disabled
      gLo_q       <= 1'b0;
      gHi_q       <= 1'b0;
      pEn_q       <= 1'b0;
      newStat_q   <= `SEE_ST_RESET;
      statPend_q  <= 1'b0;
      statAbort_q <= 1'b0;
      wrCnt_q     <= 7'h00;
      arrayPend_q <= 1'b0;
      arrayBad_q  <= 1'b0;
      twc_q       <= 32'h0;
      progArray_q <= 1'b0;
      pageBase_q  <= {AB{1'b0}};
      busy        <= 1'b0;
      sdOut       <= 1'b0;
      sdOutEnN    <= 1'b1;
    end else begin
      // Self-timed cycle countdown
      if (busy) begin
        if (twc_q != 32'h0) begin
          twc_q <= twc_q - 32'h1;
        end else if (!fOutValid || !progArray_q) begin
          busy    <= 1'b0;
          latch_q <= 1'b0;
        end
      end
      // New transaction
      if (selFall) begin
        state_q     <= ST_OP;
        bitCnt_q    <= 3'h0;
        addrHi_q    <= 1'b0;
        wrCnt_q     <= 7'h00;
        statAbort_q <= 1'b0;
      end
      // Deselect: float output, maybe start cycle
      if (selRise) begin
        sdOutEnN <= 1'b1;
        state_q  <= ST_IGN;
        if (!busy && arrayPend_q && wrCnt_q != 7'h00) begin
          busy        <= 1'b1;
          progArray_q <= 1'b1;
          twc_q       <= TWC32;
        end else if (!busy && statPend_q && !statAbort_q) begin
          busy        <= 1'b1;
          progArray_q <= 1'b0;
          twc_q       <= TWC32;
          pEn_q       <= newStat_q[`SEE_ST_PIN_EN];
          gHi_q       <= newStat_q[`SEE_ST_GUARD_HI];
          gLo_q       <= newStat_q[`SEE_ST_GUARD_LO];
        end
        if (op_q == `SEE_OP_SET_LATCH && !busy)
          latch_q <= 1'b1; // Set only on deselect
        arrayPend_q <= 1'b0;
        statPend_q  <= 1'b0;
        op_q        <= 8'h00;
      end
      // Pin falling mid status write aborts it when enable is set
      if (selLow && statPend_q && pEn_q && pinLow)
        statAbort_q <= 1'b1;
      // Falling edge: drive next output bit
      if (clkFall && (state_q == ST_RDAT || state_q == ST_SDAT)) begin
        sdOutEnN  <= 1'b0;
        sdOut     <= outByte_q[7]; // MSB first
        outByte_q <= {outByte_q[6:0], 1'b0};
      end
      // Rising edge: sample input
      if (clkRise && !selFall) begin
        shift_q  <= nextIn;
        bitCnt_q <= bitCnt_q + 3'h1;
        case (state_q)
          ST_OP: begin
            if (bitCnt_q == 3'h7) begin
              op_q <= nextIn;
              if (busy && nextIn != `SEE_OP_RDSTAT) begin
                state_q <= ST_IGN;
              end else begin
                case (nextIn)
                  `SEE_OP_READ, `SEE_OP_WRITE: state_q <= ST_ADDR;
                  `SEE_OP_RDSTAT: begin
                    state_q   <= ST_SDAT;
                    outByte_q <= statByte;
                  end
                  `SEE_OP_STAT_WRITE: begin
                    state_q <= ST_WDAT; // Status data byte follows
                  end
                  `SEE_OP_CLR_LATCH: begin
                    latch_q <= 1'b0;
                    state_q <= ST_IGN;
                  end
                  `SEE_OP_SET_LATCH: state_q <= ST_IGN;
                  default: state_q <= ST_IGN; // Output stays floating
                endcase
              end
            end
          end
          ST_ADDR: begin
            if (bitCnt_q == 3'h7) begin
              addr_q <= {addr_q[7:0], nextIn};
              addrHi_q <= 1'b1;
              if (addrHi_q) begin
                ptr_q      <= {addr_q[AB-9:0], nextIn}; // Upper bits dropped
                pageBase_q <= {addr_q[AB-9:0], nextIn};
                if (op_q == `SEE_OP_READ) begin
                  state_q   <= ST_RDAT;
                  outByte_q <= mem[{addr_q[AB-9:0], nextIn}];
                end else begin
                  state_q     <= ST_WDAT;
                  arrayPend_q <= latch_q;
                  arrayBad_q  <= guarded({addr_q[AB-9:0], nextIn}, gHi_q, gLo_q);
                end
              end
            end
          end
          ST_WDAT: begin
            if (bitCnt_q == 3'h7) begin
              if (op_q == `SEE_OP_STAT_WRITE) begin
                newStat_q <= nextIn & `SEE_ST_WR_MASK;
                // Needs latch and no pin guard
                statPend_q <= latch_q && !(pEn_q && pinLow);
                state_q    <= ST_IGN;
              end else begin
                ptr_q <= {ptr_q[AB-1:PB], ptr_q[PB-1:0] + 1'b1}; // Page wrap
                if (wrCnt_q != PAGE7) wrCnt_q <= wrCnt_q + 7'h1;
              end
            end
          end
          ST_RDAT: begin
            if (bitCnt_q == 3'h7) begin
              ptr_q     <= ptr_q + 1'b1; // Wraps to zero at top
              outByte_q <= mem[ptr_q + 1'b1];
            end
          end
          ST_SDAT: begin
            if (bitCnt_q == 3'h7) outByte_q <= statByte; // Repeats status
          end
          default: state_q <= ST_IGN;
        endcase
      end
    end
  end
endmodule // see_spi_eeprom

/* File: test/see_spi_eeprom_asserts.sv */
`timescale 1ns/1ps
module see_spi_eeprom_asserts #(
  parameter TWC_CYCLES = 625000
) (
  // System
  input wire clk_sys,
  input wire rst,
  // Serial pins
  input wire selN,
  input wire sclk,
  input wire sdIn,
  input wire guardPinN,
  input wire sdOut,
  input wire sdOutEnN,
  input wire busy
);
  reg [31:0] busyCnt_q;  // Cycles spent busy so far
  // Length of the running write cycle
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busyCnt_q <= 32'h0;
    end else begin
      busyCnt_q <= busy ? busyCnt_q + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_idle_floats: assert property (selN [*6] |-> sdOutEnN)
    else $error("output driven while deselected");
  a_release_prompt: assert property ($rose(selN) |-> ##[1:5] sdOutEnN)
    else $error("output not released after deselect");
  a_drive_in_frame: assert property ($fell(sdOutEnN) |-> !selN)
    else $error("output enabled outside a frame");
  a_drive_after_fall: assert property ($fell(sdOutEnN) |-> $past(!sclk, 2))
    else $error("output enabled away from a falling clock");
  a_steady_clock_high: assert property ($rose(sclk) |-> ##2 $stable(sdOut) [*2])
    else $error("data out moved while clock high");
  a_busy_at_release: assert property ($rose(busy) |-> selN && $past(selN))
    else $error("write cycle began inside a frame");
  a_busy_holds: assert property ($rose(busy) |=> busy [*8])
    else $error("busy dropped early");
  a_busy_length: assert property ($fell(busy) |-> busyCnt_q + 32'h2 >= TWC_CYCLES
    && busyCnt_q <= TWC_CYCLES + 2) else $error("write cycle length wrong");
  c_write_cycle: cover property ($rose(busy));
  c_data_out: cover property ($fell(sdOutEnN));
  c_status_busy: cover property (busy && !sdOutEnN);
endmodule // see_spi_eeprom_asserts
bind see_spi_eeprom see_spi_eeprom_asserts #(.TWC_CYCLES(TWC_CYCLES)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .selN(selN), .sclk(sclk), .sdIn(sdIn),
  .guardPinN(guardPinN), .sdOut(sdOut), .sdOutEnN(sdOutEnN), .busy(busy));

/* File: test/see_host_model.sv */
`timescale 1ns/1ps
// Host side, mode 0,0 or 1,1: clock parked low or high between frames
module see_host_model (
  // Clock
  input  wire clk_sys,
  // Serial pins
  output reg  selN,
  output reg  sclk,
  output reg  sdIn,
  input  wire sdOut,
  input  wire sdOutEnN
);
  reg drove;  // Device drove the line this frame
  reg lineQ;  // Level seen on the data line
  reg idleHigh;  // Mode 1,1 when set
  initial begin
    idleHigh = 1'b0;
    selN = 1'b1;
    sclk = 1'b0;
    sdIn = 1'b0;
    drove = 1'b0;
    lineQ = 1'b0;
  end
  // Half a 64 ns link period
  task half;
    repeat (4) @(posedge clk_sys);
  endtask
  // Park the clock for the chosen mode between frames
  task set_mode(input m);
    idleHigh = m;
    sclk <= m;
    half;
  endtask
  task begin_f;
    @(posedge clk_sys);
    drove = 1'b0;
    selN <= 1'b0;
    half;
  endtask
  // Deselect, then park data opposite, as a released line is not held
  task end_f;
    half;
    selN <= 1'b1;
    sdIn <= ~sdIn;
    repeat (2) half;
  endtask
  task xfer(input [7:0] tx, output [7:0] r);
    integer b;
    for (b = 7; b >= 0; b = b - 1) begin
      if (idleHigh) sclk <= 1'b0;  // Mode 1,1 falls first
      sdIn <= tx[b];
      half;
      sclk <= 1'b1;
      half;
      lineQ = (sdOutEnN === 1'b0) ? sdOut : ~lineQ;
      drove = drove | (sdOutEnN === 1'b0);
      r[b] = lineQ;
      if (!idleHigh) sclk <= 1'b0;
    end
  endtask
endmodule // see_host_model

/* File: test/see_spi_eeprom_bench.sv */
`timescale 1ns/1ps
module see_spi_eeprom_bench;
  localparam TWC = 1000;  // Shortened write cycle
  reg         clk_sys = 1'b0;
  reg         rst = 1'b1;
  reg         guardPinN = 1'b1;
  wire        selN, sclk, sdIn, sdOut, sdOutEnN, busy;
  integer     err_count = 0;
  integer     n_compared = 0;
  integer     cyc = 0, i, j, g, k, w;
  reg  [7:0]  rx, st, op, arg, msk, ex;
  reg  [15:0] a;
  reg         pin, p;
  reg  [7:0]  mem [0:8191];  // Expected array image
  reg  [32:0] rows [0:9];    // Op, argument, mask, status, pin
  always #4 clk_sys = ~clk_sys;
  see_spi_eeprom #(.TWC_CYCLES(TWC)) u_dut (.clk_sys(clk_sys), .rst(rst), .selN(selN),
    .sclk(sclk), .sdIn(sdIn), .guardPinN(guardPinN), .sdOut(sdOut), .sdOutEnN(sdOutEnN),
    .busy(busy));
  see_host_model u_host (.clk_sys(clk_sys), .selN(selN), .sclk(sclk), .sdIn(sdIn),
    .sdOut(sdOut), .sdOutEnN(sdOutEnN));
  task complete_run;
    if (err_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 90000) begin
      err_count = err_count + 1;
      complete_run;
    end
  end
  task check(input [7:0] seen, input [7:0] want);
    n_compared = n_compared + 1;
    if (seen !== want) begin
      err_count = err_count + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // Wait out a write cycle, bounded
  task settle;
    w = 0;
    repeat (8) @(posedge clk_sys);
    while (busy !== 1'b0 && w < 2000) begin
      @(posedge clk_sys);
      w = w + 1;
    end
  endtask
  task cmd(input [7:0] c);
    u_host.begin_f;
    u_host.xfer(c, rx);
    u_host.end_f;
  endtask
  task rdst;
    u_host.begin_f;
    u_host.xfer(8'h05, rx);
    u_host.xfer(8'h00, st);
    u_host.end_f;
  endtask
  // Status write; pin dropped before (1) or after (2) deselect
  task stw(input [7:0] v, input [1:0] drop);
    cmd(8'h06);
    u_host.begin_f;
    u_host.xfer(8'h01, rx);
    u_host.xfer(v, rx);
    if (drop == 2'h1) guardPinN <= 1'b0;
    u_host.end_f;
    if (drop == 2'h2) guardPinN <= 1'b0;
    settle;
    guardPinN <= 1'b1;
  endtask
  task wr(input [15:0] ad, input integer n, input [23:0] d);
    cmd(8'h06);
    u_host.begin_f;
    u_host.xfer(8'h02, rx);
    u_host.xfer(ad[15:8], rx);
    u_host.xfer(ad[7:0], rx);
    for (j = 0; j < n; j = j + 1) u_host.xfer(d[23-8*j -: 8], rx);
    u_host.end_f;
  endtask
  task rd(input [15:0] ad, input [7:0] e0, input [7:0] e1, input two);
    u_host.begin_f;
    u_host.xfer(8'h03, rx);
    u_host.xfer(ad[15:8], rx);
    u_host.xfer(ad[7:0], rx);
    u_host.xfer(8'h00, rx);
    check(rx, e0);
    u_host.xfer(8'h00, rx);
    if (two) check(rx, e1);
    u_host.end_f;
  endtask
  initial begin
    rows[0] = {8'h04, 8'h00, 8'hFF, 8'h00, 1'b1};
    rows[1] = {8'h06, 8'h00, 8'hFF, 8'h02, 1'b1};
    rows[2] = {8'h04, 8'h00, 8'hFF, 8'h00, 1'b1};
    rows[3] = {8'h01, 8'h8C, 8'hFF, 8'h00, 1'b1};
    rows[4] = {8'h06, 8'h00, 8'hFF, 8'h02, 1'b1};
    rows[5] = {8'h01, 8'hFF, 8'hFF, 8'h8C, 1'b1};
    rows[6] = {8'h5A, 8'h00, 8'hFF, 8'h8C, 1'b1};
    rows[7] = {8'h06, 8'h00, 8'hFF, 8'h8E, 1'b1};
    rows[8] = {8'h01, 8'h00, 8'hFD, 8'h8C, 1'b0};
    rows[9] = {8'h01, 8'h00, 8'hFF, 8'h00, 1'b1};
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rdst;
    check(st, 8'h00);
    // Latch, status and unknown commands, one frame per row
    for (i = 0; i < 10; i = i + 1) begin
      {op, arg, msk, ex, pin} = rows[i];
      guardPinN <= pin;
      u_host.begin_f;
      u_host.xfer(op, rx);
      if (op == 8'h01) u_host.xfer(arg, rx);
      u_host.end_f;
      check({7'h00, u_host.drove}, 8'h00);
      settle;
      rdst;
      check(st & msk, ex);
    end
    guardPinN <= 1'b1;
    // Every guard pair against three block starts
    for (g = 0; g < 4; g = g + 1) begin
      stw({4'h0, g[1:0], 2'b00}, 2'h0);
      for (k = 0; k < 3; k = k + 1) begin
        a = (k == 0) ? 16'h0000 : ((k == 1) ? 16'h1000 : 16'h1800);
        p = (g == 3) || (g == 2 && k > 0) || (g == 1 && k == 2);
        wr(a | 16'hE000, 1, {8'h50 + g[7:0], 16'h0000});
        settle;
        if (!p) mem[a[12:0]] = 8'h50 + g[7:0];
        rd(a, mem[a[12:0]], 8'h00, 1'b0);
      end
    end
    stw(8'h00, 2'h0);
    // Page wrap, then commands while busy
    wr(16'h003E, 3, {8'h11, 8'h22, 8'h33});
    rdst;
    check(st, 8'h03);
    check({7'h00, busy}, 8'h01);
    u_host.begin_f;
    u_host.xfer(8'h03, rx);
    u_host.xfer(8'h00, rx);
    u_host.xfer(8'h00, rx);
    u_host.xfer(8'h00, rx);
    u_host.end_f;
    check({7'h00, u_host.drove}, 8'h00);
    settle;
    rdst;
    check(st, 8'h00);
    wr(16'h1FFF, 1, {8'h44, 16'h0000});
    settle;
    rd(16'h003E, 8'h11, 8'h22, 1'b1);
    rd(16'h1FFF, 8'h44, 8'h33, 1'b1);
    // Pin falling inside the frame, then after the cycle started
    stw(8'h80, 2'h0);
    stw(8'h8C, 2'h1);
    rdst;
    check(st & 8'h8C, 8'h80);
    stw(8'h00, 2'h2);
    rdst;
    check(st, 8'h00);
    // Mode 1,1: clock parked high between frames
    u_host.set_mode(1'b1);
    rd(16'h003E, 8'h11, 8'h22, 1'b1);
    rdst;
    check(st, 8'h00);
    u_host.set_mode(1'b0);
    // Mid-run reset drops a set latch
    cmd(8'h06);
    rdst;
    check(st, 8'h02);
    rst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rdst;
    check(st, 8'h00);
    complete_run;
  end
endmodule // see_spi_eeprom_bench
